// ==== bench/smbus_host_model.sv ====
// SMBus host model: clock source and open-drain data line with pull-up
`timescale 1ns/10ps
`default_nettype none
module smbus_host_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic core_clk,
  input  wire logic dev_oe,
  output logic      scl,
  output wire logic sda
);
  logic pull;
  // Released line floats to the pull-up level
  assign sda = ~(pull | dev_oe);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic start();
    pull <= 1'b0;
    w(13);
    scl <= 1'b1;
    w(12);
    pull <= 1'b1;
    w(12);
    scl <= 1'b0;
  endtask
  task automatic stop();
    w(3);
    pull <= 1'b1;
    w(10);
    scl <= 1'b1;
    w(12);
    pull <= 1'b0;
    w(12);
  endtask
  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    w(3);
    pull <= ~b;
    w(10);
    scl <= 1'b1;
    w(6);
    r = sda;
    w(6);
    scl <= 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(last, r);
    ack = ~r;
  endtask
  task automatic probe(input logic [6:0] ad, output logic ok);
    logic [7:0] q;
    start();
    byte_io({ad, 1'b0}, 1'b1, q, ok);
    stop();
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, output logic ok);
    logic [7:0] q;
    logic a, b, e, f;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, q, a);
    byte_io(c, 1'b1, q, b);
    byte_io(d[7:0], 1'b1, q, e);
    byte_io(d[15:8], 1'b1, q, f);
    stop();
    ok = a & b & e & f;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
    logic [7:0] q;
    logic a, b, e, n;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, q, a);
    byte_io(c, 1'b1, q, b);
    start();
    byte_io({ADDR, 1'b1}, 1'b1, q, e);
    byte_io(8'hFF, 1'b0, d[7:0], n);
    byte_io(8'hFF, 1'b1, d[15:8], n);
    stop();
    ok = a & b & e;
  endtask
  // Both lines low for a long time switches the pack off
  task automatic hold_low(input logic v);
    if (v) begin
      scl <= 1'b0;
      w(2);
      pull <= 1'b1;
    end else begin
      pull <= 1'b0;
      w(2);
      scl <= 1'b1;
    end
  endtask
endmodule // smbus_host_model
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the battery alarm and mode register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  import battery_regs_pkg::*;
  localparam logic [15:0] DCAP = 16'h0FA0;
  localparam int          HOLD = 100;
  logic        core_clk, rst_n, scl, sda_oe, condition_request, condition_done;
  logic        on_state, capacity_alarm, time_alarm, alert_due;
  logic        charger_broadcast_en, charger_ctrl_en, primary_role, unit_power;
  logic [15:0] charge_left, mean_runtime_left;
  wire         sda;
  int          fail_count, comparisons;
  battery_alarm_mode_regs #(.DESIGN_CAPACITY(DCAP), .OFF_CYCLES(200), .HOLD_CYCLES(HOLD))
  battery_alarm_mode_regs_i (
    .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .charge_left(charge_left), .mean_runtime_left(mean_runtime_left),
    .condition_request(condition_request), .condition_done(condition_done),
    .on_state(on_state), .capacity_alarm(capacity_alarm), .time_alarm(time_alarm),
    .alert_due(alert_due), .charger_broadcast_en(charger_broadcast_en),
    .charger_ctrl_en(charger_ctrl_en), .primary_role(primary_role),
    .unit_power(unit_power));
  smbus_host_model smbus_host_model_i (
    .core_clk(core_clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
  task automatic test_done();
    $display("Counts: %0d mismatches, %0d comparisons", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check_word(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_bit(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wrc(input logic [7:0] c, input logic [15:0] d);
    logic ok;
    smbus_host_model_i.wr(c, d, ok);
    check_bit("write ack", 1'b1, ok);
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    logic        ok;
    logic [15:0] d;
    smbus_host_model_i.rd(c, d, ok);
    check_bit("read ack", 1'b1, ok);
    check_word("read word", e, d);
  endtask
  // Bounded wait for the pack state
  task automatic wait_on(input logic v);
    for (int i = 0; i < 400; i++) begin
      if (on_state === v) return;
      cyc(1);
    end
    fail_count++;
    $display("[ERR] on_state expected %b seen %b", v, on_state);
    test_done();
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    logic ok;
    rst_n = 1'b0;
    charge_left = 16'hFFFF;
    mean_runtime_left = 16'hFFFF;
    condition_request = 1'b0;
    condition_done = 1'b0;
    cyc(8);
    rst_n <= 1'b1;
    wait_on(1'b1);
    cyc(HOLD + 5);
    rdc(CMD_MAKER_WORD, MAKER_WORD_RESET);
    rdc(CMD_LOW_CAPACITY, 16'(32'(DCAP) * CAP_ALARM_PCT / 100));
    rdc(CMD_LOW_TIME, LOW_TIME_RESET);
    rdc(CMD_MODE_WORD, 16'h0003);
    check_bit("broadcast", 1'b1, charger_broadcast_en);
    wrc(CMD_MAKER_WORD, 16'hA55A);
    rdc(CMD_MAKER_WORD, 16'hA55A);
    wrc(CMD_LOW_CAPACITY, 16'hFFFF);
    rdc(CMD_LOW_CAPACITY, 16'hFFFF);
    wrc(CMD_MODE_WORD, 16'hC3FF);
    rdc(CMD_MODE_WORD, 16'hC303);
    check_bit("ctrl_en", 1'b1, charger_ctrl_en);
    check_bit("primary", 1'b1, primary_role);
    check_bit("units", 1'b1, unit_power);
    check_bit("broadcast", 1'b0, charger_broadcast_en);
    condition_request <= 1'b1;
    cyc(1);
    condition_request <= 1'b0;
    rdc(CMD_MODE_WORD, 16'hC383);
    condition_done <= 1'b1;
    cyc(1);
    condition_done <= 1'b0;
    rdc(CMD_MODE_WORD, 16'hC303);
    rdc(8'h10, 16'h0000);
    smbus_host_model_i.probe(7'h2B, ok);
    check_bit("foreign ack", 1'b0, ok);
    // Threshold boundary: one below alarms, equal does not
    wrc(CMD_LOW_CAPACITY, 16'h0100);
    charge_left <= 16'h00FF;
    cyc(4);
    check_bit("cap alarm", 1'b1, capacity_alarm);
    check_bit("alert", 1'b1, alert_due);
    charge_left <= 16'h0100;
    cyc(4);
    check_bit("cap alarm", 1'b0, capacity_alarm);
    wrc(CMD_LOW_CAPACITY, 16'h0000);
    charge_left <= 16'h0000;
    cyc(4);
    check_bit("cap alarm", 1'b0, capacity_alarm);
    mean_runtime_left <= 16'h0009;
    cyc(4);
    check_bit("time alarm", 1'b1, time_alarm);
    wrc(CMD_LOW_TIME, 16'h0000);
    check_bit("time alarm", 1'b0, time_alarm);
    wrc(CMD_LOW_CAPACITY, 16'h0100);
    smbus_host_model_i.hold_low(1'b1);
    cyc(250);
    check_bit("on", 1'b0, on_state);
    smbus_host_model_i.hold_low(1'b0);
    wait_on(1'b1);
    cyc(50);
    check_bit("alert", 1'b0, alert_due);
    cyc(60);
    check_bit("alert", 1'b1, alert_due);
    rdc(CMD_MODE_WORD, 16'h0003);
    check_bit("units", 1'b0, unit_power);
    check_bit("ctrl_en", 1'b0, charger_ctrl_en);
    rdc(CMD_LOW_CAPACITY, 16'h0100);
    test_done();
  end
endmodule // tb
`default_nettype wire

// ==== inc/battery_regs_pkg.sv ====
// Constants shared by the battery alarm and mode register bank
package battery_regs_pkg;
  localparam logic [7:0]  CMD_MAKER_WORD   = 8'h00;
  localparam logic [7:0]  CMD_LOW_CAPACITY = 8'h01;
  localparam logic [7:0]  CMD_LOW_TIME     = 8'h02;
  localparam logic [7:0]  CMD_MODE_WORD    = 8'h03;

  localparam int          BIT_INT_CHARGER  = 0;
  localparam int          BIT_ROLE_SUPPORT = 1;
  localparam int          BIT_CONDITION    = 7;
  localparam int          BIT_CHARGER_EN   = 8;
  localparam int          BIT_PRIMARY      = 9;
  localparam int          BIT_NO_BROADCAST = 14;
  localparam int          BIT_UNIT_POWER   = 15;

  localparam logic [15:0] MAKER_WORD_RESET = 16'h0000;
  localparam logic [15:0] LOW_TIME_RESET   = 16'h000A;
  localparam logic [15:0] MODE_HI_RESET    = 16'h0000;
  localparam int          CAP_ALARM_PCT    = 10;

  localparam longint unsigned CLK_HZ       = 200_000_000;
  localparam longint unsigned OFF_TIME_MS  = 2_000;
  localparam longint unsigned HOLD_TIME_MS = 10_000;
  // Least times, rounded up to whole cycles
  localparam longint unsigned OFF_CYCLES_DFLT  = (OFF_TIME_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned HOLD_CYCLES_DFLT = (HOLD_TIME_MS * CLK_HZ + 999) / 1000;

  localparam logic [3:0]  LAST_DATA_BIT    = 4'h7;
  localparam logic [3:0]  ACK_BIT          = 4'h8;

  typedef enum logic [6:0] {
    SM_IDLE = 7'h01,
    SM_ADDR = 7'h02,
    SM_CMD  = 7'h04,
    SM_WLO  = 7'h08,
    SM_WHI  = 7'h10,
    SM_RLO  = 7'h20,
    SM_RHI  = 7'h40
  } bus_state_t;
endpackage : battery_regs_pkg

// ==== rtl/battery_alarm_mode_regs.sv ====
// Battery alarm thresholds and operating mode word behind an SMBus word slave
`timescale 1ns/10ps
`default_nettype none
module battery_alarm_mode_regs
  import battery_regs_pkg::*;
#(
  parameter logic [6:0]  SLAVE_ADDR      = 7'h2A,
  parameter logic [15:0] DESIGN_CAPACITY = 16'h0FA0,
  parameter bit          HAS_CHARGER     = 1'b1,
  parameter bit          HAS_ROLE        = 1'b1,
  parameter int unsigned OFF_CYCLES      = 32'(battery_regs_pkg::OFF_CYCLES_DFLT),
  parameter int unsigned HOLD_CYCLES     = 32'(battery_regs_pkg::HOLD_CYCLES_DFLT)
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [15:0] charge_left,
  input  wire logic [15:0] mean_runtime_left,
  input  wire logic        condition_request,
  input  wire logic        condition_done,
  output logic             on_state,
  output logic             capacity_alarm,
  output logic             time_alarm,
  output logic             alert_due,
  output logic             charger_broadcast_en,
  output logic             charger_ctrl_en,
  output logic             primary_role,
  output logic             unit_power
);
  import battery_regs_pkg::*;

  localparam logic [15:0] CAP_RESET = 16'(32'(DESIGN_CAPACITY) * CAP_ALARM_PCT / 100);

  logic [1:0]  scl_sync;
  logic [1:0]  sda_sync;
  logic        scl_q;
  logic        sda_q;
  bus_state_t  state;
  logic [3:0]  bitcnt;
  logic [7:0]  shreg;
  logic [7:0]  cmd;
  logic [7:0]  lo_byte;
  logic        master_ack;
  logic        rise_seen;
  logic [15:0] maker_defined_word;
  logic [15:0] low_capacity_threshold;
  logic [15:0] low_time_threshold;
  logic [3:0]  mode_hi;
  logic        condition_flag;
  logic [31:0] off_count;
  logic [31:0] hold_count;
  logic        hold_done;

  wire scl      = scl_sync[1];
  wire sda      = sda_sync[1];
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start    = scl & scl_q & sda_q & ~sda;
  wire stop     = scl & scl_q & ~sda_q & sda;
  wire rx_phase = (state == SM_ADDR) | (state == SM_CMD) | (state == SM_WLO) | (state == SM_WHI);
  wire tx_phase = (state == SM_RLO) | (state == SM_RHI);
  wire addr_hit = shreg[7:1] == SLAVE_ADDR;
  wire byte_end = scl_fall & (bitcnt == LAST_DATA_BIT);
  wire wr_commit = byte_end & (state == SM_WHI);
  wire [15:0] wr_word = {shreg, lo_byte};
  wire enter_on  = ~on_state & scl;
  wire enter_off = on_state & (off_count >= OFF_CYCLES);

  // Lower byte is built live, so host writes can never reach it
  wire [15:0] operating_mode_word = {mode_hi[3], mode_hi[2], 4'h0, mode_hi[1], mode_hi[0],
                                     condition_flag, 5'h00, HAS_ROLE, HAS_CHARGER};

  function automatic logic [15:0] read_word(input logic [7:0] code);
    unique case (code)
      CMD_MAKER_WORD:   read_word = maker_defined_word;
      CMD_LOW_CAPACITY: read_word = low_capacity_threshold;
      CMD_LOW_TIME:     read_word = low_time_threshold;
      CMD_MODE_WORD:    read_word = operating_mode_word;
      default:          read_word = 16'h0000;
    endcase
  endfunction

  wire [15:0] rd_word = read_word(cmd);

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 2'b00;
      sda_sync <= 2'b00;
      scl_q    <= 1'b0;
      sda_q    <= 1'b0;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q    <= scl;
      sda_q    <= sda;
    end
  end

  // Byte-level slave: data on rising SCL, drive on falling SCL
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= SM_IDLE;
      bitcnt     <= 4'h0;
      shreg      <= 8'h00;
      cmd        <= 8'h00;
      lo_byte    <= 8'h00;
      master_ack <= 1'b0;
      sda_oe     <= 1'b0;
      rise_seen  <= 1'b0;
    end else if (start) begin
      state     <= SM_ADDR;
      bitcnt    <= 4'h0;
      sda_oe    <= 1'b0;
      // Fall that ends a start carries no bit, so it must not count
      rise_seen <= 1'b0;
    end else if (stop || !on_state) begin
      state  <= SM_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      rise_seen <= 1'b1;
      if (rx_phase && bitcnt < ACK_BIT) begin
        shreg <= {shreg[6:0], sda};
      end
      if (tx_phase && bitcnt == ACK_BIT) begin
        master_ack <= ~sda;
      end
    end else if (scl_fall && rise_seen && state != SM_IDLE) begin
      if (bitcnt < LAST_DATA_BIT) begin
        bitcnt <= bitcnt + 4'h1;
        if (tx_phase) begin
          sda_oe <= ~shreg[6];
          shreg  <= {shreg[6:0], 1'b0};
        end
      end else if (bitcnt == LAST_DATA_BIT) begin
        bitcnt <= ACK_BIT;
        sda_oe <= rx_phase & ((state != SM_ADDR) | addr_hit);
        if (state == SM_ADDR && !addr_hit) begin
          state <= SM_IDLE;
        end
        if (state == SM_CMD) begin
          cmd <= shreg;
        end
        if (state == SM_WLO) begin
          lo_byte <= shreg;
        end
      end else begin
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
        unique case (state)
          SM_ADDR: begin
            if (shreg[0]) begin
              state  <= SM_RLO;
              shreg  <= rd_word[7:0];
              sda_oe <= ~rd_word[7];
            end else begin
              state <= SM_CMD;
            end
          end
          SM_CMD:  state <= SM_WLO;
          SM_WLO:  state <= SM_WHI;
          SM_RLO: begin
            if (master_ack) begin
              state  <= SM_RHI;
              shreg  <= rd_word[15:8];
              sda_oe <= ~rd_word[15];
            end else begin
              state <= SM_IDLE;
            end
          end
          default: state <= SM_IDLE;
        endcase
      end
    end
  end

  // Thresholds survive on/off; only a command write changes them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      maker_defined_word     <= MAKER_WORD_RESET;
      low_capacity_threshold <= CAP_RESET;
      low_time_threshold     <= LOW_TIME_RESET;
    end else if (wr_commit) begin
      if (cmd == CMD_MAKER_WORD) begin
        maker_defined_word <= wr_word;
      end
      if (cmd == CMD_LOW_CAPACITY) begin
        low_capacity_threshold <= wr_word;
      end
      if (cmd == CMD_LOW_TIME) begin
        low_time_threshold <= wr_word;
      end
    end
  end

  // Unsupported options never latch, so readback shows the real state
  wire [3:0] next_mode_wr = {wr_word[BIT_UNIT_POWER], wr_word[BIT_NO_BROADCAST],
                             wr_word[BIT_PRIMARY] & HAS_ROLE,
                             wr_word[BIT_CHARGER_EN] & HAS_CHARGER};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_hi <= MODE_HI_RESET[3:0];
    end else if (enter_on) begin
      mode_hi <= {2'b00, mode_hi[1:0]};
    end else if (enter_off) begin
      mode_hi <= {mode_hi[3:2], 2'b00};
    end else if (wr_commit && cmd == CMD_MODE_WORD) begin
      mode_hi <= next_mode_wr;
    end
  end

  // Request wins over a same-cycle completion
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      condition_flag <= 1'b0;
    end else if (condition_request) begin
      condition_flag <= 1'b1;
    end else if (condition_done) begin
      condition_flag <= 1'b0;
    end
  end

  // Off after both lines low for the full time; on at any SCL high
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_state   <= 1'b0;
      off_count  <= 32'h0000_0000;
      hold_count <= 32'h0000_0000;
    end else begin
      if (enter_on) begin
        on_state <= 1'b1;
      end else if (enter_off) begin
        on_state <= 1'b0;
      end
      off_count  <= (scl | sda | ~on_state) ? 32'h0000_0000 : off_count + 32'h1;
      if (!on_state || enter_off) begin
        hold_count <= 32'h0000_0000;
      end else if (!hold_done) begin
        hold_count <= hold_count + 32'h1;
      end
    end
  end

  assign hold_done = hold_count >= HOLD_CYCLES;

  // Measurements arrive already in the units that unit_power asks for
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      capacity_alarm       <= 1'b0;
      time_alarm           <= 1'b0;
      alert_due            <= 1'b0;
      charger_broadcast_en <= 1'b0;
      charger_ctrl_en      <= 1'b0;
      primary_role         <= 1'b0;
      unit_power           <= 1'b0;
    end else begin
      capacity_alarm       <= charge_left < low_capacity_threshold;
      time_alarm           <= mean_runtime_left < low_time_threshold;
      alert_due            <= on_state & hold_done & (capacity_alarm | time_alarm);
      charger_broadcast_en <= on_state & hold_done & ~mode_hi[2];
      charger_ctrl_en      <= mode_hi[0] & HAS_CHARGER;
      primary_role         <= mode_hi[1] & HAS_ROLE;
      unit_power           <= mode_hi[3];
    end
  end

  sequence quiet_after_on;
    !alert_due [*8];
  endsequence

  chk_cap_zero_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    capacity_alarm |-> $past(low_capacity_threshold) != 16'h0000)
    else $error("capacity alarm with zero threshold");
  chk_cap_alarm_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    (charge_left < low_capacity_threshold) |=> capacity_alarm)
    else $error("capacity alarm missed");
  chk_time_zero_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    time_alarm |-> $past(low_time_threshold) != 16'h0000)
    else $error("time alarm with zero threshold");
  chk_time_alarm_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mean_runtime_left < low_time_threshold) |=> time_alarm)
    else $error("time alarm missed");
  chk_mode_low_ro: assert property (@(posedge core_clk) disable iff (!rst_n)
    operating_mode_word[6:0] == {5'h00, HAS_ROLE, HAS_CHARGER})
    else $error("mode low byte corrupted");
  chk_cond_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
    condition_request |=> operating_mode_word[BIT_CONDITION])
    else $error("condition request lost");
  chk_on_clears_units: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(on_state) |-> operating_mode_word[15:14] == 2'b00)
    else $error("mode bits not cleared on entry");
  chk_off_clears_roles: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(on_state) |-> operating_mode_word[9:8] == 2'b00)
    else $error("role bits not cleared on exit");
  chk_holdoff_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(on_state) |-> quiet_after_on)
    else $error("alert during holdoff");
  chk_suppress_bcast: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode_hi[2] |=> !charger_broadcast_en)
    else $error("broadcast while suppressed");
endmodule // battery_alarm_mode_regs
`default_nettype wire
